// ---- rtl/dscc_pkg.sv ----
// constants and types shared by the channel configuration register bank
package dscc_pkg;
  // ---------------------------------------------------------------
  // clock and fault timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int FT_LSB_NS = 500000;
  localparam int FT_CODE_MAX = 31;
  localparam int FT_CYC_W = 18;
  // ---------------------------------------------------------------
  // register indices and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_HA_LIM = 4'h0;
  localparam logic [3:0] REG_HA_FLT = 4'h1;
  localparam logic [3:0] REG_LA_FLT = 4'h2;
  localparam logic [3:0] REG_HB_LIM = 4'h3;
  localparam logic [3:0] REG_SYS = 4'h6;
  localparam logic [3:0] REG_STAT = 4'h7;
  localparam logic [7:0] RST_LIM = 8'hbf;
  localparam logic [7:0] RST_FLT = 8'h01;
  localparam logic [7:0] RD_NONE = 8'h00;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LIM_LSB = 0;
  localparam int PG0_BIT = 4;
  localparam int PG1_BIT = 5;
  localparam int HP_BIT = 6;
  localparam int OR_BIT = 7;
  localparam int EN_BIT = 5;
  localparam int UV_BIT = 6;
  localparam int DS_BIT = 7;
  localparam int SYS_RESTART_BIT = 1;
  localparam int STAT_HA_FLT_BIT = 1;
  localparam int STAT_LA_FLT_BIT = 3;
  // ---------------------------------------------------------------
  // analog settings in their own units
  // ---------------------------------------------------------------
  localparam int PCT_FULL = 100;
  localparam int LIM_FLOOR_PCT = 25;
  localparam int LIM_STEP_PCT = 5;
  localparam int FAST_TRIP_MAX_MV = 100;
  localparam int PG_MAX_MV = 10500;
  localparam int PG_STEP0_MV = 600;
  localparam int PG_STEP1_MV = 1200;
  localparam logic [3:0] OROFF_NEG_MV = 4'hd;
  localparam logic [3:0] OROFF_POS_MV = 4'h3;
  // ---------------------------------------------------------------
  // serial port
  // ---------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_MARK = 4'h9;
  localparam int SYNC_W = 5;
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_EN3 = 2;
  localparam int SY_LOWH = 3;
  localparam int SY_LOWL = 4;
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_AACK, S_WBYTE, S_WACK, S_RBYTE, S_RACK
  } dscc_i2c_e;
endpackage

// ---- rtl/dscc_sync.sv ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module dscc_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // raw and filtered levels
  input wire logic [dscc_pkg::SYNC_W-1:0] din,
  output logic [dscc_pkg::SYNC_W-1:0] dout
);
  import dscc_pkg::*;
  // scl and sda idle high, the rail pins idle low
  localparam logic [SYNC_W-1:0] IDLE_LVL = SYNC_W'((1 << SY_SCL) | (1 << SY_SDA));
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] val;
  } dscc_sync_s;
  dscc_sync_s q;
  dscc_sync_s n;
  logic [SYNC_W-1:0] val_d;
  // a change counts only once stages two and three agree
  for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
    assign val_d[i] = (q.s2[i] == q.s3[i]) ? q.s2[i] : q.val[i];
  end
  always_comb begin
    n = q;
    n.s1 = din;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.val = val_d;
  end
  // idle-high reset keeps a released bus from looking like a start
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= {4{IDLE_LVL}};
    end else begin
      q <= n;
    end
  end
  assign dout = q.val;
endmodule

// ---- rtl/dscc_regs.sv ----
// channel configuration register bank behind a two-wire serial port
`timescale 1ns/1ns
module dscc_regs #(
  parameter int FT_STEP_CYC = dscc_pkg::FT_LSB_NS / dscc_pkg::CLK_PERIOD_NS,
  parameter logic [6:0] DEV_ADDR = 7'h40
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // serial port
  input wire logic i2c_scl,
  input wire logic i2c_sda_in,
  output logic i2c_sda_out,
  output logic i2c_sda_oe,
  // pins and analog events
  input wire logic lo_rail_a_enable_pin,
  input wire logic hi_rail_a_output_low,
  input wire logic lo_rail_a_output_low,
  input wire logic hi_rail_a_timer_expired,
  input wire logic lo_rail_a_timer_expired,
  // first high rail settings
  output logic [6:0] hi_rail_a_limit_pct,
  output logic [6:0] hi_rail_a_fast_trip_mv,
  output logic [13:0] hi_rail_a_good_mv,
  output logic [3:0] hi_rail_a_oring_off_mv,
  output logic [dscc_pkg::FT_CYC_W-1:0] hi_rail_a_fault_cycles,
  output logic hi_rail_a_bleed_select,
  // first high rail gates
  output logic hi_rail_a_pass_gate,
  output logic hi_rail_a_block_gate,
  // first low rail
  output logic [dscc_pkg::FT_CYC_W-1:0] lo_rail_a_fault_cycles,
  output logic lo_rail_a_gate,
  output logic lo_rail_a_bleed_select,
  // second high rail
  output logic [6:0] hi_rail_b_limit_pct,
  output logic [6:0] hi_rail_b_fast_trip_mv,
  output logic [13:0] hi_rail_b_good_mv,
  output logic [3:0] hi_rail_b_oring_off_mv,
  output logic hi_rail_b_block_gate
);
  import dscc_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    dscc_i2c_e st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic first;
    logic nack;
    logic [3:0] ptr;
    logic scl_p;
    logic sda_p;
    logic sda_oe;
    logic sda_lvl;
    logic [3:0][7:0] cfg;
    logic restart;
    logic flt_ha;
    logic flt_la;
    logic lat_ha;
    logic lat_la;
    logic pass_ha;
    logic blk_ha;
    logic gate_la;
    logic blk_hb;
    logic [6:0] pct_ha;
    logic [6:0] trip_ha;
    logic [6:0] pct_hb;
    logic [6:0] trip_hb;
    logic [13:0] pg_ha;
    logic [13:0] pg_hb;
    logic [3:0] off_ha;
    logic [3:0] off_hb;
    logic [FT_CYC_W-1:0] ft_ha;
    logic [FT_CYC_W-1:0] ft_la;
    logic bleed_ha;
    logic bleed_la;
  } dscc_state_s;
  dscc_state_s q;
  dscc_state_s n;

  // ---------------------------------------------------------------
  // synchronised inputs and bus conditions
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] sy;
  logic scl_v;
  logic sda_v;
  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;
  logic [7:0] rd_data;

  dscc_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .din({lo_rail_a_output_low, hi_rail_a_output_low, lo_rail_a_enable_pin,
          i2c_sda_in, i2c_scl}),
    .dout(sy)
  );

  assign scl_v = sy[SY_SCL];
  assign sda_v = sy[SY_SDA];
  assign start_c = scl_v && q.scl_p && q.sda_p && !sda_v;
  assign stop_c = scl_v && q.scl_p && !q.sda_p && sda_v;
  assign rise_c = scl_v && !q.scl_p;
  assign fall_c = !scl_v && q.scl_p;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_data = RD_NONE;
    if (q.ptr <= REG_HB_LIM) begin
      rd_data = q.cfg[q.ptr[1:0]];
    end else if (q.ptr == REG_SYS) begin
      rd_data[SYS_RESTART_BIT] = q.restart;
    end else if (q.ptr == REG_STAT) begin
      rd_data[STAT_HA_FLT_BIT] = q.flt_ha;
      rd_data[STAT_LA_FLT_BIT] = q.flt_la;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic do_load;
    logic do_wr;
    logic clr;
    logic [7:0] ca;
    logic [7:0] fa;
    logic [7:0] la;
    logic [7:0] cb;
    do_load = 1'b0;
    do_wr = 1'b0;
    clr = 1'b0;
    ca = q.cfg[REG_HA_LIM];
    fa = q.cfg[REG_HA_FLT];
    la = q.cfg[REG_LA_FLT];
    cb = q.cfg[REG_HB_LIM];
    n = q;
    n.scl_p = scl_v;
    n.sda_p = sda_v;
    // a start or stop anywhere aborts the byte in progress
    if (start_c) begin
      n.st = S_ADDR;
      n.bitcnt = '0;
      n.sda_oe = 1'b0;
    end else if (stop_c) begin
      n.st = S_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        S_IDLE: n.st = S_IDLE;
        S_ADDR: begin
          if (rise_c) begin
            n.shreg = {q.shreg[6:0], sda_v};
            n.bitcnt = q.bitcnt + 4'h1;
          end else if (fall_c && q.bitcnt == BYTE_BITS) begin
            if (q.shreg[7:1] == DEV_ADDR) begin
              n.sda_oe = 1'b1;
              n.rw = q.shreg[0];
              n.st = S_AACK;
            end else begin
              n.st = S_IDLE;
            end
          end
        end
        S_AACK: begin
          if (rise_c) begin
            n.bitcnt = ACK_MARK;
          end else if (fall_c && q.bitcnt == ACK_MARK) begin
            if (q.rw) begin
              do_load = 1'b1;
            end else begin
              n.sda_oe = 1'b0;
              n.bitcnt = '0;
              n.first = 1'b1;
              n.st = S_WBYTE;
            end
          end
        end
        S_WBYTE: begin
          if (rise_c) begin
            n.shreg = {q.shreg[6:0], sda_v};
            n.bitcnt = q.bitcnt + 4'h1;
          end else if (fall_c && q.bitcnt == BYTE_BITS) begin
            n.sda_oe = 1'b1;
            n.st = S_WACK;
            do_wr = 1'b1;
          end
        end
        S_WACK: begin
          if (rise_c) begin
            n.bitcnt = ACK_MARK;
          end else if (fall_c && q.bitcnt == ACK_MARK) begin
            n.sda_oe = 1'b0;
            n.bitcnt = '0;
            n.st = S_WBYTE;
          end
        end
        S_RBYTE: begin
          if (fall_c) begin
            if (q.bitcnt == BYTE_BITS - 4'h1) begin
              n.sda_oe = 1'b0;
              n.bitcnt = BYTE_BITS;
              n.st = S_RACK;
            end else begin
              n.shreg = {q.shreg[6:0], 1'b0};
              n.sda_oe = !q.shreg[6];
              n.bitcnt = q.bitcnt + 4'h1;
            end
          end
        end
        S_RACK: begin
          if (rise_c) begin
            n.nack = sda_v;
            n.bitcnt = ACK_MARK;
          end else if (fall_c && q.bitcnt == ACK_MARK) begin
            if (q.nack) begin
              n.st = S_IDLE;
            end else begin
              do_load = 1'b1;
            end
          end
        end
      endcase
    end
    // open drain: drive low only for a zero bit
    if (do_load) begin
      n.shreg = rd_data;
      n.sda_oe = !rd_data[7];
      n.ptr = q.ptr + 4'h1;
      n.bitcnt = '0;
      n.st = S_RBYTE;
      clr = (q.ptr == REG_STAT);
    end
    // first byte after the address is the register pointer
    if (do_wr) begin
      if (q.first) begin
        n.ptr = q.shreg[3:0];
        n.first = 1'b0;
      end else begin
        if (q.ptr <= REG_HB_LIM) begin
          n.cfg[q.ptr[1:0]] = q.shreg;
        end else if (q.ptr == REG_SYS) begin
          n.restart = q.shreg[SYS_RESTART_BIT];
        end
        n.ptr = q.ptr + 4'h1;
      end
    end
    // set wins over the read clear so no expiry is lost
    n.flt_ha = (q.flt_ha && !clr) || hi_rail_a_timer_expired;
    n.flt_la = (q.flt_la && !clr) || lo_rail_a_timer_expired;

    // -------------------------------------------------------------
    // channel settings
    // -------------------------------------------------------------
    n.pct_ha = 7'(LIM_FLOOR_PCT + LIM_STEP_PCT * int'(ca[LIM_LSB+:4]));
    n.pct_hb = 7'(LIM_FLOOR_PCT + LIM_STEP_PCT * int'(cb[LIM_LSB+:4]));
    n.trip_ha = 7'((FAST_TRIP_MAX_MV * int'(n.pct_ha)) / PCT_FULL);
    n.trip_hb = 7'((FAST_TRIP_MAX_MV * int'(n.pct_hb)) / PCT_FULL);
    n.pg_ha = 14'(PG_MAX_MV - (ca[PG0_BIT] ? 0 : PG_STEP0_MV)
                  - (ca[PG1_BIT] ? 0 : PG_STEP1_MV));
    n.pg_hb = 14'(PG_MAX_MV - (cb[PG0_BIT] ? 0 : PG_STEP0_MV)
                  - (cb[PG1_BIT] ? 0 : PG_STEP1_MV));
    n.off_ha = ca[HP_BIT] ? OROFF_POS_MV : OROFF_NEG_MV;
    n.off_hb = cb[HP_BIT] ? OROFF_POS_MV : OROFF_NEG_MV;
    n.ft_ha = FT_CYC_W'(int'(fa[4:0]) * FT_STEP_CYC);
    n.ft_la = FT_CYC_W'(int'(la[4:0]) * FT_STEP_CYC);
    n.bleed_ha = fa[DS_BIT];
    n.bleed_la = la[DS_BIT];

    // -------------------------------------------------------------
    // gate control
    // -------------------------------------------------------------
    // latch-off holds until software drops the master enable
    n.lat_ha = fa[EN_BIT] && (q.lat_ha || (hi_rail_a_timer_expired && !q.restart));
    n.lat_la = la[EN_BIT] && (q.lat_la || (lo_rail_a_timer_expired && !q.restart));
    n.pass_ha = fa[EN_BIT] && !q.lat_ha
                && (q.pass_ha || !fa[UV_BIT] || sy[SY_LOWH]);
    n.blk_ha = n.pass_ha && ca[OR_BIT];
    n.gate_la = la[EN_BIT] && sy[SY_EN3] && !q.lat_la
                && (q.gate_la || !la[UV_BIT] || sy[SY_LOWL]);
    n.blk_hb = cb[OR_BIT];
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.cfg[REG_HA_LIM] <= RST_LIM;
      q.cfg[REG_HA_FLT] <= RST_FLT;
      q.cfg[REG_LA_FLT] <= RST_FLT;
      q.cfg[REG_HB_LIM] <= RST_LIM;
      q.blk_hb <= 1'b1;
      q.pct_ha <= 7'(PCT_FULL);
      q.pct_hb <= 7'(PCT_FULL);
      q.trip_ha <= 7'(FAST_TRIP_MAX_MV);
      q.trip_hb <= 7'(FAST_TRIP_MAX_MV);
      q.pg_ha <= 14'(PG_MAX_MV);
      q.pg_hb <= 14'(PG_MAX_MV);
      q.off_ha <= OROFF_NEG_MV;
      q.off_hb <= OROFF_NEG_MV;
      q.ft_ha <= FT_CYC_W'(FT_STEP_CYC);
      q.ft_la <= FT_CYC_W'(FT_STEP_CYC);
    end else begin
      q <= n;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign i2c_sda_out = q.sda_lvl;
  assign i2c_sda_oe = q.sda_oe;
  assign hi_rail_a_limit_pct = q.pct_ha;
  assign hi_rail_a_fast_trip_mv = q.trip_ha;
  assign hi_rail_a_good_mv = q.pg_ha;
  assign hi_rail_a_oring_off_mv = q.off_ha;
  assign hi_rail_a_fault_cycles = q.ft_ha;
  assign hi_rail_a_bleed_select = q.bleed_ha;
  assign hi_rail_a_pass_gate = q.pass_ha;
  assign hi_rail_a_block_gate = q.blk_ha;
  assign lo_rail_a_fault_cycles = q.ft_la;
  assign lo_rail_a_gate = q.gate_la;
  assign lo_rail_a_bleed_select = q.bleed_la;
  assign hi_rail_b_limit_pct = q.pct_hb;
  assign hi_rail_b_fast_trip_mv = q.trip_hb;
  assign hi_rail_b_good_mv = q.pg_hb;
  assign hi_rail_b_oring_off_mv = q.off_hb;
  assign hi_rail_b_block_gate = q.blk_hb;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb_chk @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_lim_step: assert property (
    q.cfg[REG_HA_LIM][3:0] == 4'he |=> q.pct_ha == 7'(PCT_FULL - LIM_STEP_PCT))
    else $error("limit step wrong");
  a_lim_floor: assert property (
    q.cfg[REG_HA_LIM][3:0] == 4'h0 |=> q.pct_ha == 7'(LIM_FLOOR_PCT) ##0 q.trip_ha == 7'(LIM_FLOOR_PCT))
    else $error("limit floor wrong");
  a_trip_full: assert property (
    &q.cfg[REG_HB_LIM][3:0] |=> q.trip_hb == 7'(FAST_TRIP_MAX_MV))
    else $error("fast trip wrong");
  a_good_floor: assert property (
    q.cfg[REG_HA_LIM][5:4] == 2'h0 |=> q.pg_ha == 14'(PG_MAX_MV - PG_STEP0_MV - PG_STEP1_MV))
    else $error("good floor wrong");
  a_oring_pos: assert property (
    q.cfg[REG_HA_LIM][HP_BIT] |=> q.off_ha == OROFF_POS_MV)
    else $error("turn-off sign wrong");
  a_permit_low: assert property (
    !q.cfg[REG_HA_LIM][OR_BIT] |=> !q.blk_ha)
    else $error("block gate not held");
  a_ft_max: assert property (
    q.cfg[REG_HA_FLT][4:0] == 5'h1f |=> q.ft_ha == FT_CYC_W'(FT_CODE_MAX * FT_STEP_CYC))
    else $error("fault time wrong");
  a_ft_low: assert property (
    q.cfg[REG_LA_FLT][4:0] == 5'h01 |=> q.ft_la == FT_CYC_W'(FT_STEP_CYC))
    else $error("low fault time wrong");
  a_en_gates: assert property (
    !q.cfg[REG_HA_FLT][EN_BIT] |=> !q.pass_ha && !q.blk_ha)
    else $error("gates on while disabled");
  a_lo_gate: assert property (
    q.gate_la |-> $past(q.cfg[REG_LA_FLT][EN_BIT]) && $past(sy[SY_EN3]))
    else $error("low gate without enables");
  a_uv_hold: assert property (
    $rose(q.pass_ha) |-> $past(!q.cfg[REG_HA_FLT][UV_BIT] || sy[SY_LOWH]))
    else $error("interlock ignored");
  a_flag_set: assert property (
    hi_rail_a_timer_expired |=> q.flt_ha)
    else $error("timeout flag lost");
  a_latch_off: assert property (
    hi_rail_a_timer_expired && !q.restart && q.cfg[REG_HA_FLT][EN_BIT]
      |=> q.lat_ha ##1 !q.pass_ha)
    else $error("latch-off missing");

  c_write_ack: cover property (q.st == S_WACK && q.ptr == REG_HA_FLT);
  c_read_ack: cover property (q.st == S_RACK);
  c_gate_on: cover property ($rose(q.pass_ha));
  c_flag_clear: cover property ($fell(q.flt_ha));
endmodule

// ---- sim/dscc_host.sv ----
// serial host model that reads and writes the channel configuration registers
`timescale 1ns/1ns
module dscc_host #(
  parameter logic [6:0] DEV_ADDR = 7'h40
) (
  // clock
  input wire logic sys_clk,
  // bus lines
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic scl_q = 1'b1;
  logic pull_q = 1'b0;
  logic bit_r;
  // released line floats to the pull-up level, never to the last driven value
  assign sda = !(pull_q || sda_oe);
  assign scl = scl_q;
  // ---------------------------------------------------------------
  // bit level, 8 clocks per phase to clear the 3-4 clock sync lag
  // ---------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    scl_q <= 1'b0;
    wt(4);
    pull_q <= !b;
    wt(4);
    scl_q <= 1'b1;
    wt(8);
    r = sda;
  endtask
  task automatic start();
    scl_q <= 1'b0;
    wt(4);
    pull_q <= 1'b0;
    wt(4);
    scl_q <= 1'b1;
    wt(8);
    pull_q <= 1'b1;
    wt(8);
  endtask
  task automatic stop();
    scl_q <= 1'b0;
    wt(4);
    pull_q <= 1'b1;
    wt(4);
    scl_q <= 1'b1;
    wt(8);
    pull_q <= 1'b0;
    wt(8);
  endtask
  // sends d msb first; ninth bit released, so ack is the device answer
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], bit_r);
      q[i] = bit_r;
    end
    bit_io(1'b1, bit_r);
    ack = !bit_r;
  endtask
  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------
  task automatic wr(input logic [3:0] ptr, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a0;
    logic a1;
    logic a2;
    start();
    xfer({DEV_ADDR, 1'b0}, q, a0);
    xfer({4'h0, ptr}, q, a1);
    xfer(d, q, a2);
    stop();
    ok = a0 && a1 && a2;
  endtask
  // read ends with a nack, which the released ninth bit gives
  task automatic rd(input logic [3:0] ptr, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a0;
    logic a1;
    logic a2;
    start();
    xfer({DEV_ADDR, 1'b0}, q, a0);
    xfer({4'h0, ptr}, q, a1);
    start();
    xfer({DEV_ADDR, 1'b1}, q, a2);
    xfer(8'hff, d, bit_r);
    stop();
    ok = a0 && a1 && a2;
  endtask
endmodule

// ---- sim/dscc_regs_tb.sv ----
// self-checking bench for the channel configuration register bank
`timescale 1ns/1ns
module dscc_regs_tb;
  import dscc_pkg::*;
  localparam int STEP = 5;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda, sda_out, sda_oe, ok;
  logic en_pin = 1'b0, ha_low = 1'b0, la_low = 1'b0, ha_exp = 1'b0, la_exp = 1'b0;
  logic [6:0] ha_pct, ha_trip, hb_pct, hb_trip;
  logic [13:0] ha_good, hb_good;
  logic [3:0] ha_off, hb_off;
  logic [FT_CYC_W-1:0] ha_cyc, la_cyc;
  logic ha_bleed, ha_pass, ha_blk, la_gate, la_bleed, hb_blk;
  logic [7:0] v, r;
  int fail_count = 0;
  int cmp_count = 0;
  always #50 sys_clk = ~sys_clk;
  dscc_host #(.DEV_ADDR(7'h40)) u_dscc_host (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl),
    .sda(sda));
  dscc_regs #(.FT_STEP_CYC(STEP), .DEV_ADDR(7'h40)) u_dscc_regs (.sys_clk(sys_clk), .rst(rst),
    .i2c_scl(scl), .i2c_sda_in(sda), .i2c_sda_out(sda_out), .i2c_sda_oe(sda_oe),
    .lo_rail_a_enable_pin(en_pin), .hi_rail_a_output_low(ha_low),
    .lo_rail_a_output_low(la_low), .hi_rail_a_timer_expired(ha_exp),
    .lo_rail_a_timer_expired(la_exp), .hi_rail_a_limit_pct(ha_pct),
    .hi_rail_a_fast_trip_mv(ha_trip), .hi_rail_a_good_mv(ha_good),
    .hi_rail_a_oring_off_mv(ha_off), .hi_rail_a_fault_cycles(ha_cyc),
    .hi_rail_a_bleed_select(ha_bleed), .hi_rail_a_pass_gate(ha_pass),
    .hi_rail_a_block_gate(ha_blk), .lo_rail_a_fault_cycles(la_cyc), .lo_rail_a_gate(la_gate),
    .lo_rail_a_bleed_select(la_bleed), .hi_rail_b_limit_pct(hb_pct),
    .hi_rail_b_fast_trip_mv(hb_trip), .hi_rail_b_good_mv(hb_good),
    .hi_rail_b_oring_off_mv(hb_off), .hi_rail_b_block_gate(hb_blk));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] d);
    u_dscc_host.rd(a, r, ok);
    chk({ok, r}, {1'b1, d});
  endtask
  task automatic wrchk(input logic [3:0] a, input logic [7:0] d);
    u_dscc_host.wr(a, d, ok);
    chk(ok, 1'b1);
    rdchk(a, d);
  endtask
  // limit code c gives 25 + 5c percent; good code g gives 8700 + 600g mV
  task automatic chk_hi(input logic [7:0] c, input logic [6:0] p, input logic [6:0] t,
    input logic [13:0] g, input logic [3:0] o);
    chk(p, 7'(25 + 5 * c[3:0]));
    chk(t, 7'(25 + 5 * c[3:0]));
    chk(g, 14'(8700 + 600 * c[5:4]));
    chk(o, c[6] ? 4'h3 : 4'hd);
  endtask
  task automatic pulse(input logic hi);
    if (hi) ha_exp <= 1'b1;
    else la_exp <= 1'b1;
    wt(1);
    ha_exp <= 1'b0;
    la_exp <= 1'b0;
    wt(4);
  endtask
  initial begin
    wt(90000);
    fail_count++;
    end_of_test();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(43282));
    wt(5);
    rst <= 1'b0;
    wt(8);
    chk_hi(RST_LIM, ha_pct, ha_trip, ha_good, ha_off);
    chk({ha_cyc, la_cyc}, {18'(STEP), 18'(STEP)});
    chk({ha_pass, ha_blk, la_gate, ha_bleed, la_bleed, hb_blk}, 6'h01);
    chk(sda_out, 1'b0);
    rdchk(REG_HA_LIM, RST_LIM);
    rdchk(REG_HA_FLT, RST_FLT);
    rdchk(REG_LA_FLT, RST_FLT);
    rdchk(REG_HB_LIM, RST_LIM);
    rdchk(4'h5, RD_NONE);
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i == 2) ? 8'h4e : 8'($urandom);
      en_pin <= 1'($urandom);
      wrchk(REG_HB_LIM, v);
      chk_hi(v, hb_pct, hb_trip, hb_good, hb_off);
      chk(hb_blk, v[7]);
      wrchk(REG_HA_LIM, v);
      chk_hi(v, ha_pct, ha_trip, ha_good, ha_off);
      v = v & 8'h9f;
      wrchk(REG_HA_FLT, v);
      chk({ha_cyc, ha_bleed}, {18'(v[4:0] * STEP), v[7]});
      chk({ha_pass, ha_blk}, 2'b00);
      wrchk(REG_LA_FLT, v);
      chk({la_cyc, la_bleed, la_gate}, {18'(v[4:0] * STEP), v[7], 1'b0});
    end
    // host settles on bleed off and the one-step fault time (code 1)
    wrchk(REG_LA_FLT, 8'h01);
    en_pin <= 1'b0;
    wrchk(REG_HA_LIM, 8'h8f);
    wrchk(REG_HA_FLT, 8'h21);
    chk({ha_pass, ha_blk}, 2'b11);
    wrchk(REG_HA_LIM, 8'h0f);
    chk({ha_pass, ha_blk}, 2'b10);
    wrchk(REG_LA_FLT, 8'h21);
    chk(la_gate, 1'b0);
    en_pin <= 1'b1;
    wt(10);
    chk(la_gate, 1'b1);
    // interlock holds off until the output has bled down
    wrchk(REG_HA_FLT, 8'h01);
    wrchk(REG_HA_FLT, 8'h61);
    wrchk(REG_LA_FLT, 8'h01);
    wrchk(REG_LA_FLT, 8'h61);
    chk({ha_pass, la_gate}, 2'b00);
    ha_low <= 1'b1;
    la_low <= 1'b1;
    wt(10);
    chk({ha_pass, la_gate}, 2'b11);
    // timer expiry with latch-off, then with restart
    pulse(1'b1);
    pulse(1'b0);
    chk({ha_pass, la_gate}, 2'b00);
    rdchk(REG_STAT, 8'h0a);
    rdchk(REG_STAT, 8'h00);
    wrchk(REG_SYS, 8'h02);
    wrchk(REG_HA_FLT, 8'h01);
    wrchk(REG_HA_FLT, 8'h21);
    pulse(1'b1);
    chk(ha_pass, 1'b1);
    rdchk(REG_STAT, 8'h02);
    // reset in mid-run restores defaults
    rst <= 1'b1;
    wt(5);
    rst <= 1'b0;
    wt(8);
    chk({ha_pass, la_gate, hb_blk}, 3'b001);
    rdchk(REG_HA_FLT, RST_FLT);
    rdchk(REG_SYS, 8'h00);
    end_of_test();
  end
endmodule
